// ===== verilog/pcc_defs.svh
// constants for the clock and pixel clock control block
// assumes an 8-bit special-function register port and a 100 MHz mclk
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define PCC_ADDR_POWER_CTRL   8'h87
`define PCC_ADDR_SRC_CTRL     8'hd7
`define PCC_ADDR_PF_HIGH      8'hda
`define PCC_ADDR_PF_LOW       8'hdb

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PCC_BIT_PD_START      6
`define PCC_BIT_SLOW_DOWN     4
`define PCC_BIT_PD_ENABLE     1
`define PCC_BIT_LOOP_PSAVE    0
`define PCC_BIT_LOOP_RESET    1
`define PCC_BIT_SRC_SELECT    2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PCC_RST_POWER_CTRL    8'h00
`define PCC_RST_SRC_CTRL      8'h00
`define PCC_RST_PF_HIGH       8'h01
`define PCC_RST_PF_LOW        8'h48

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PCC_MCLK_MHZ          100
`define PCC_LOOP_MHZ          300
`define PCC_SYS_MHZ_X100      3333
// loop ticks folded into one mclk cycle
`define PCC_LOOP_PER_MCLK     (`PCC_LOOP_MHZ / `PCC_MCLK_MHZ)
// mclk cycles per full-speed system clock period
`define PCC_SYS_DIV           ((`PCC_MCLK_MHZ * 100) / `PCC_SYS_MHZ_X100)
`define PCC_SLOW_DIV          4
`define PCC_OSC_DIV           2
`define PCC_DTO_ACC_W         13

`endif

// ===== verilog/pcc_pkg.sv
// types shared by the clock and pixel clock control block
// assumes pcc_defs.svh carries all numeric constants
package pcc_pkg;

  // system clock source selection states
  typedef enum logic [1:0] {
    src_loop   = 2'b00,
    src_to_osc = 2'b01,
    src_osc    = 2'b10,
    src_to_loop = 2'b11
  } pcc_src_state_t;

  // one special-function register access, same clock as the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } pcc_sfr_req_t;

endpackage

// ===== verilog/pcc_dto.sv
// digital time oscillator producing pixel clock enable pulses
// assumes one mclk cycle stands for STEPS ticks of the loop clock
`timescale 1ns/10ps

module pcc_dto #(
  parameter int PF_W  = 11,
  parameter int ACC_W = 13,
  parameter int STEPS = 3
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            run,
  input  wire logic            realign,
  input  wire logic [PF_W-1:0] factor,
  output logic                 pulse
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  // more than one carry per cycle would be lost, so the step must stay below 2^ACC_W
  if ((STEPS * ((1 << PF_W) - 1)) >= (1 << ACC_W)) begin : g_bad_width
    $error("pcc_dto: factor range overflows the phase accumulator");
  end

  // ----------------------------------------------------------------------------
  // phase accumulator
  // ----------------------------------------------------------------------------
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0]   sum;
  logic [ACC_W:0]   step;

  // frequency = factor * loop / 2^ACC_W, periods vary but the mean is exact
  assign step = (ACC_W+1)'(STEPS * int'(factor));
  assign sum  = {1'b0, acc_q} + step;

  // phase restarts on each line so the first pixel follows the sync edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      pulse <= 1'b0;
    end else if (!run || realign) begin
      acc_q <= '0;
      pulse <= 1'b0;
    end else begin
      acc_q <= sum[ACC_W-1:0];
      pulse <= sum[ACC_W];
    end
  end

endmodule

// ===== verilog/pcc_clock_ctrl.sv
// clock control: loop power save, loop reset, system clock source, slow-down,
// power down and the programmable pixel clock
// assumes the core drives sfr requests and insn_end on mclk; all pins are async
`timescale 1ns/10ps
`include "pcc_defs.svh"

// Contract
// - loop runs at 300 MHz from the oscillator and may be bypassed to save power
// - one system clock of 33.33 MHz derived from the loop feeds the core side
// - slow-down mode runs the system clock at one quarter rate
// - loop power save stops the loop, uses oscillator clock, shuts video blocks
// - loop power save can only be set while source select already reads 1
// - source select 0 takes loop clock at full speed, 1 takes oscillator clock
// - loop held in reset while the loop reset bit is 1
// - power down starts only if enable was set by the previous instruction
// - power down stops both the loop and the oscillator
// - pixel clock is 11-bit factor times loop frequency over 8192
// - pixel factor resets to 328, about 12 MHz
// - pixel clock phase realigned to each rising horizontal sync edge
// - pixel clock spans 10 to 32 MHz and drives display output side
// - external pixel clock may replace internal one, locked to external sync
module pcc_clock_ctrl #(
  parameter int PF_W = 11
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire pcc_pkg::pcc_sfr_req_t sfr,
  input  wire logic                insn_end,
  input  wire logic                osc_clk_pin,
  input  wire logic                hsync_pin,
  input  wire logic                ext_pix_pin,
  input  wire logic                ext_pix_sel_pin,
  input  wire logic                wake_pin,
  output logic [7:0]               sfr_rdata,
  output logic                     loop_run,
  output logic                     loop_reset,
  output logic                     osc_run,
  output logic                     sys_clk_en,
  output logic                     pix_clk_en,
  output logic                     video_off,
  output logic                     power_down
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  if (PF_W < 9 || PF_W > 11) begin : g_bad_pf
    $error("pcc_clock_ctrl: factor width must split into a high and a low byte");
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [2:0]       prev_q;
  wire  [NSYNC-1:0] pins = {wake_pin, ext_pix_sel_pin, ext_pix_pin, hsync_pin, osc_clk_pin};

  // first stage only feeds the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q[2:0];
    end
  end

  wire osc_s     = sync_q[0];
  wire hsync_s   = sync_q[1];
  wire ext_pix_s = sync_q[2];
  wire ext_sel_s = sync_q[3];
  wire wake_s    = sync_q[4];
  wire osc_rise  = osc_s & ~prev_q[0];
  wire hs_rise   = hsync_s & ~prev_q[1];
  wire ext_rise  = ext_pix_s & ~prev_q[2];

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  logic [7:0]      pwr_ctrl_q;
  logic            src_sel_q;
  logic            loop_rst_q;
  logic            lps_q;
  logic [PF_W-1:0] pf_q;
  logic            pde_wr_q;
  logic            pde_prev_q;
  logic            pd_q;

  // address decode
  wire wr_pwr  = sfr.we && (sfr.addr == `PCC_ADDR_POWER_CTRL);
  wire wr_src  = sfr.we && (sfr.addr == `PCC_ADDR_SRC_CTRL);
  wire wr_pfh  = sfr.we && (sfr.addr == `PCC_ADDR_PF_HIGH);
  wire wr_pfl  = sfr.we && (sfr.addr == `PCC_ADDR_PF_LOW);
  wire pde_set = wr_pwr && sfr.wdata[`PCC_BIT_PD_ENABLE];
  wire pds_req = wr_pwr && sfr.wdata[`PCC_BIT_PD_START];
  wire slow_on = pwr_ctrl_q[`PCC_BIT_SLOW_DOWN];

  // reset value of the factor assembled from the two byte resets
  localparam logic [15:0] PF_RST = {`PCC_RST_PF_HIGH, `PCC_RST_PF_LOW};

  // power control byte; the start bit is never stored so it reads back 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctrl_q <= `PCC_RST_POWER_CTRL;
    end else if (wr_pwr) begin
      pwr_ctrl_q <= sfr.wdata & ~(8'h01 << `PCC_BIT_PD_START);
    end
  end

  // reset image of the source control byte; a literal cannot be bit-selected directly
  localparam logic [7:0] SRC_RST = `PCC_RST_SRC_CTRL;

  // loop source control byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_sel_q  <= SRC_RST[`PCC_BIT_SRC_SELECT];
      loop_rst_q <= SRC_RST[`PCC_BIT_LOOP_RESET];
      lps_q      <= SRC_RST[`PCC_BIT_LOOP_PSAVE];
    end else if (wr_src) begin
      src_sel_q  <= sfr.wdata[`PCC_BIT_SRC_SELECT];
      loop_rst_q <= sfr.wdata[`PCC_BIT_LOOP_RESET];
      // a set only sticks if the oscillator source was already chosen
      lps_q      <= sfr.wdata[`PCC_BIT_LOOP_PSAVE] & src_sel_q;
    end
  end

  // pixel frequency factor, split across two bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pf_q <= PF_RST[PF_W-1:0];
    end else if (wr_pfh) begin
      pf_q[PF_W-1:8] <= sfr.wdata[PF_W-9:0];
    end else if (wr_pfl) begin
      pf_q[7:0] <= sfr.wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // power down entry
  // ----------------------------------------------------------------------------
  // pde_wr_q marks a setting write inside the current instruction, pde_prev_q
  // keeps it alive for exactly the next instruction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pde_wr_q   <= 1'b0;
      pde_prev_q <= 1'b0;
    end else if (insn_end) begin
      pde_wr_q   <= 1'b0;
      pde_prev_q <= pde_wr_q | pde_set;
    end else if (pde_set) begin
      pde_wr_q   <= 1'b1;
    end
  end

  // entry beats a wake in the same cycle so a fresh request is not lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
    end else if (pds_req && pde_prev_q) begin
      pd_q <= 1'b1;
    end else if (wake_s) begin
      pd_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // system clock sources
  // ----------------------------------------------------------------------------
  wire loop_ok = !lps_q && !loop_rst_q && !pd_q;
  logic [1:0] sys_div_q;
  logic       osc_half_q;

  // loop path: mclk divided to the full-speed system rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_q <= 2'h0;
    end else if (!loop_ok || sys_div_q == 2'(`PCC_SYS_DIV - 1)) begin
      sys_div_q <= 2'h0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  // oscillator path: every other oscillator edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_half_q <= 1'b0;
    end else if (osc_rise && !pd_q) begin
      osc_half_q <= ~osc_half_q;
    end
  end

  wire loop_tick = loop_ok && (sys_div_q == 2'(`PCC_SYS_DIV - 1));
  wire osc_tick  = osc_rise && osc_half_q && !pd_q;

  // ----------------------------------------------------------------------------
  // glitch-free source switch
  // ----------------------------------------------------------------------------
  // the old source finishes its period before the new one is taken (a stopped loop is left at once),
  // trading two lost ticks per switch, the old source's last and the new source's first, for clean minimum periods
  pcc_pkg::pcc_src_state_t src_q;
  pcc_pkg::pcc_src_state_t src_d;

  always_comb begin
    src_d = src_q;
    case (src_q)
      pcc_pkg::src_loop:    if (src_sel_q && (loop_tick || !loop_ok)) src_d = pcc_pkg::src_to_osc;
      pcc_pkg::src_to_osc:  if (osc_tick) src_d = pcc_pkg::src_osc;
      pcc_pkg::src_osc:     if (!src_sel_q && osc_tick) src_d = pcc_pkg::src_to_loop;
      pcc_pkg::src_to_loop: if (loop_tick) src_d = pcc_pkg::src_loop;
      default:              src_d = pcc_pkg::src_loop;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= pcc_pkg::src_loop;
    end else begin
      src_q <= src_d;
    end
  end

  wire sel_tick = ((src_q == pcc_pkg::src_loop) && src_d == pcc_pkg::src_loop && loop_tick) ||
                  ((src_q == pcc_pkg::src_osc) && src_d == pcc_pkg::src_osc && osc_tick);

  // ----------------------------------------------------------------------------
  // slow-down prescaler
  // ----------------------------------------------------------------------------
  logic [1:0] slow_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= 2'h0;
    end else if (!slow_on) begin
      slow_q <= 2'h0;
    end else if (sel_tick) begin
      slow_q <= slow_q + 2'h1;
    end
  end

  wire sys_tick = sel_tick && (!slow_on || slow_q == 2'(`PCC_SLOW_DIV - 1));

  // ----------------------------------------------------------------------------
  // pixel clock
  // ----------------------------------------------------------------------------
  logic dto_pulse;
  // external source bypasses the internal oscillator; its phase is the
  // far end's business, so only its edge is forwarded
  wire  dto_run = loop_ok && !ext_sel_s && !lps_q;

  pcc_dto #(
    .PF_W  (PF_W),
    .ACC_W (`PCC_DTO_ACC_W),
    .STEPS (`PCC_LOOP_PER_MCLK)
  ) u_dto (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .run     (dto_run),
    .realign (hs_rise),
    .factor  (pf_q),
    .pulse   (dto_pulse)
  );

  wire pix_tick = !pd_q && (ext_sel_s ? ext_rise : dto_pulse);

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  wire [7:0] rd_src = {5'h00, src_sel_q, loop_rst_q, lps_q};
  wire [7:0] rd_pfh = 8'(pf_q[PF_W-1:8]);
  wire [7:0] rd_val = (sfr.addr == `PCC_ADDR_POWER_CTRL) ? pwr_ctrl_q :
                      (sfr.addr == `PCC_ADDR_SRC_CTRL)   ? rd_src :
                      (sfr.addr == `PCC_ADDR_PF_HIGH)    ? rd_pfh :
                      (sfr.addr == `PCC_ADDR_PF_LOW)     ? pf_q[7:0] : 8'h00;

  // ----------------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata  <= 8'h00;
      loop_run   <= 1'b0;
      loop_reset <= 1'b0;
      osc_run    <= 1'b0;
      sys_clk_en <= 1'b0;
      pix_clk_en <= 1'b0;
      video_off  <= 1'b0;
      power_down <= 1'b0;
    end else begin
      if (sfr.re) begin
        sfr_rdata <= rd_val;
      end
      loop_run   <= !lps_q && !pd_q;
      loop_reset <= loop_rst_q;
      osc_run    <= !pd_q;
      sys_clk_en <= sys_tick;
      pix_clk_en <= pix_tick;
      video_off  <= lps_q || pd_q;
      power_down <= pd_q;
    end
  end

endmodule

// ===== testbench/pcc_clock_ctrl_props.sv
// concurrent checks on the clock control block ports
// assumes it is bound onto pcc_clock_ctrl and shares its mclk domain
`timescale 1ns/10ps
`include "pcc_defs.svh"

module pcc_props (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire pcc_pkg::pcc_sfr_req_t sfr,
  input wire logic                  insn_end,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  loop_run,
  input wire logic                  loop_reset,
  input wire logic                  osc_run,
  input wire logic                  sys_clk_en,
  input wire logic                  pix_clk_en,
  input wire logic                  video_off,
  input wire logic                  power_down
);
  // -------------------------------------------------------------------------
  // helper logic
  // -------------------------------------------------------------------------
  // mirror of the stored loop reset bit, updated on the same edge as the register
  logic lres_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lres_q <= 1'b0;
    end else if (sfr.we && sfr.addr == `PCC_ADDR_SRC_CTRL) begin
      lres_q <= sfr.wdata[`PCC_BIT_LOOP_RESET];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // -------------------------------------------------------------------------
  // power down entry steps
  // -------------------------------------------------------------------------
  sequence s_pde_wr;
    sfr.we && sfr.addr == `PCC_ADDR_POWER_CTRL && sfr.wdata == 8'h02;
  endsequence
  sequence s_pds_wr;
    sfr.we && sfr.addr == `PCC_ADDR_POWER_CTRL && sfr.wdata[`PCC_BIT_PD_START];
  endsequence

  // the start write sets the internal flag, the output flop follows one edge later
  AST_PD_ENTRY: assert property (s_pde_wr ##2 insn_end ##2 s_pds_wr |=> ##1 power_down)
    else $error("power down not entered after armed start");
  AST_PD_CAUSE: assert property ($rose(power_down) |-> $past(sfr.we, 2) &&
    $past(sfr.addr, 2) == `PCC_ADDR_POWER_CTRL && $past(sfr.wdata[`PCC_BIT_PD_START], 2))
    else $error("power down entered without a start write");
  AST_PD_STOP: assert property (power_down |-> !osc_run && !loop_run)
    else $error("loop or oscillator running in power down");
  AST_PIX_QUIET: assert property (power_down [*4] |-> !pix_clk_en)
    else $error("pixel pulse during power down");
  // both outputs sit at 0 in reset, so the first edge after release is skipped
  AST_VIDEO_LOOP: assert property ($past(rst_n) |-> video_off == !loop_run)
    else $error("video shut-off disagrees with loop state");
  AST_LRES: assert property ($stable(lres_q) |-> loop_reset == lres_q)
    else $error("loop reset output differs from stored bit");
  AST_SYS_PULSE: assert property (sys_clk_en |=> !sys_clk_en)
    else $error("system clock pulses back to back");
  AST_RD_PDS: assert property (sfr.re && sfr.addr == `PCC_ADDR_POWER_CTRL
    |=> !sfr_rdata[`PCC_BIT_PD_START])
    else $error("power down start read back as one");
  AST_RD_HIGH: assert property (sfr.re && sfr.addr == `PCC_ADDR_PF_HIGH
    |=> sfr_rdata[7:3] == 5'h00)
    else $error("unused factor high bits read nonzero");
endmodule

bind pcc_clock_ctrl pcc_props i_pcc_props (
  .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .insn_end(insn_end), .sfr_rdata(sfr_rdata),
  .loop_run(loop_run), .loop_reset(loop_reset), .osc_run(osc_run),
  .sys_clk_en(sys_clk_en), .pix_clk_en(pix_clk_en), .video_off(video_off),
  .power_down(power_down)
);

// ===== testbench/tb.sv
// self-checking bench for the clock and pixel clock control block
// assumes pcc_pkg, pcc_defs.svh and the bound checker are compiled with it
`timescale 1ns/10ps
`include "pcc_defs.svh"

module tb;
  logic                  mclk, rst_n, insn_end, osc, hsync, ext_pix, ext_sel, wake;
  logic                  loop_run, loop_reset, osc_run, sys_en, pix_en, video_off, pd;
  pcc_pkg::pcc_sfr_req_t sfr;
  logic [7:0]            rdata;
  logic [16:0]           lfsr;
  logic [10:0]           fv;
  logic [2:0]            oc;
  int                    err_count, checked, n, t1, t2;

  pcc_clock_ctrl i_pcc_clock_ctrl (
    .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .insn_end(insn_end), .osc_clk_pin(osc),
    .hsync_pin(hsync), .ext_pix_pin(ext_pix), .ext_pix_sel_pin(ext_sel),
    .wake_pin(wake), .sfr_rdata(rdata), .loop_run(loop_run), .loop_reset(loop_reset),
    .osc_run(osc_run), .sys_clk_en(sys_en), .pix_clk_en(pix_en), .video_off(video_off),
    .power_down(pd));

  // -------------------------------------------------------------------------
  // clocks and helpers
  // -------------------------------------------------------------------------
  always #5 mclk = ~mclk;
  // oscillator pin near 6 MHz, stepped on mclk so it never races the sampling edge
  always @(posedge mclk) begin
    oc <= oc + 3'h1;
    if (oc == 3'h7) osc <= ~osc;
  end

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // mean pixel pulses over a window of mclk cycles: factor times loop rate over 8192
  function automatic int pix_expect(input int f, input int cyc);
    return (f * `PCC_LOOP_MHZ * cyc) / (8192 * `PCC_MCLK_MHZ);
  endfunction
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // rates are counted over a window, so one pulse of slack either way
  task automatic near(input string name, input int got, input int exp);
    check(name, (got + 1 >= exp && got <= exp + 1), 1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) sfr <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk) sfr.we <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) sfr <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) sfr.re <= 1'b0;
    #1 check(name, rdata, e);
  endtask
  task automatic insn();
    @(posedge mclk) insn_end <= 1'b1;
    @(posedge mclk) insn_end <= 1'b0;
  endtask
  task automatic count(input int cyc, input bit pix, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge mclk);
      #1 c += ((pix ? pix_en : sys_en) === 1'b1);
    end
  endtask
  task automatic settle(input int cyc);
    repeat (cyc) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about 30k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    give_verdict();
  end

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    mclk = 0;
    rst_n = 0;
    sfr = '0;
    insn_end = 0;
    osc = 0;
    oc = 0;
    hsync = 0;
    ext_pix = 0;
    ext_sel = 0;
    wake = 0;
    lfsr = 17'h12fa8;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values and an unmapped read
    rchk("power_control", `PCC_ADDR_POWER_CTRL, `PCC_RST_POWER_CTRL);
    rchk("src_control", `PCC_ADDR_SRC_CTRL, `PCC_RST_SRC_CTRL);
    rchk("pf_high_rst", `PCC_ADDR_PF_HIGH, `PCC_RST_PF_HIGH);
    rchk("pf_low_rst", `PCC_ADDR_PF_LOW, `PCC_RST_PF_LOW);
    rchk("unmapped", 8'h86, 8'h00);
    // factor read back and average pixel rate, corners then random, never above 874
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      fv = (i == 0) ? 11'd874 : (i == 1) ? 11'd273 : 11'(lfsr % 875);
      wr(`PCC_ADDR_PF_HIGH, {5'h00, fv[10:8]});
      wr(`PCC_ADDR_PF_LOW, fv[7:0]);
      rchk("pf_high", `PCC_ADDR_PF_HIGH, {5'h00, fv[10:8]});
      rchk("pf_low", `PCC_ADDR_PF_LOW, fv[7:0]);
      count(4096, 1, n);
      near("pix_rate", n, pix_expect(int'(fv), 4096));
    end
    // realign: first pulse after an hsync rise lands at a fixed distance
    wr(`PCC_ADDR_PF_HIGH, 8'h01);
    wr(`PCC_ADDR_PF_LOW, 8'h48);
    for (int i = 0; i < 2; i++) begin
      lfsr = lfsr_next(lfsr);
      repeat (int'(lfsr[3:0]) + 3) @(posedge mclk);
      hsync <= 1'b1;
      settle(8);
      t1 = 8;
      while (pix_en !== 1'b1 && t1 < 60) begin
        settle(1);
        t1++;
      end
      check("realign_seen", t1 < 60, 1);
      if (i == 1) check("realign", t1, t2);
      t2 = t1;
      @(posedge mclk) hsync <= 1'b0;
    end
    // external pixel clock: 20 rising edges give 20 pulses
    @(posedge mclk) ext_sel <= 1'b1;
    settle(10);
    n = 0;
    for (int i = 0; i < 206; i++) begin
      @(posedge mclk);
      if (i % 5 == 0 && i < 200) ext_pix <= ~ext_pix;
      #1 n += (pix_en === 1'b1);
    end
    check("ext_pix", n, 20);
    @(posedge mclk) ext_sel <= 1'b0;
    // system clock at full speed, then slowed by four
    count(300, 0, n);
    near("sys_full", n, 100);
    wr(`PCC_ADDR_POWER_CTRL, 8'h10);
    settle(30);
    count(1200, 0, n);
    near("sys_slow", n, 100);
    wr(`PCC_ADDR_POWER_CTRL, 8'h00);
    // power save is refused until the oscillator source is already selected
    wr(`PCC_ADDR_SRC_CTRL, 8'h01);
    rchk("psave_refused", `PCC_ADDR_SRC_CTRL, 8'h00);
    wr(`PCC_ADDR_SRC_CTRL, 8'h05);
    rchk("psave_same_write", `PCC_ADDR_SRC_CTRL, 8'h04);
    wr(`PCC_ADDR_SRC_CTRL, 8'h05);
    rchk("psave_set", `PCC_ADDR_SRC_CTRL, 8'h05);
    settle(40);
    check("loop_stopped", loop_run, 1'b0);
    check("video_off", video_off, 1'b1);
    count(640, 0, n);
    near("sys_osc", n, 20);
    count(200, 1, n);
    check("pix_in_save", n, 0);
    // leave power save: clear, pulse loop reset, wait, back to loop clock
    wr(`PCC_ADDR_SRC_CTRL, 8'h04);
    wr(`PCC_ADDR_SRC_CTRL, 8'h06);
    settle(2);
    check("loop_reset_on", loop_reset, 1'b1);
    count(40, 1, n);
    check("pix_in_reset", n, 0);
    wr(`PCC_ADDR_SRC_CTRL, 8'h04);
    settle(2);
    check("loop_reset_off", loop_reset, 1'b0);
    settle(400);
    wr(`PCC_ADDR_SRC_CTRL, 8'h00);
    // the switch back waits for an oscillator tick and a loop tick first
    settle(50);
    check("loop_back", loop_run, 1'b1);
    count(300, 0, n);
    near("sys_back", n, 100);
    // power down: refused without enable, refused when enable is stale, then taken
    wr(`PCC_ADDR_POWER_CTRL, 8'h40);
    settle(3);
    check("pd_no_enable", pd, 1'b0);
    wr(`PCC_ADDR_POWER_CTRL, 8'h02);
    insn();
    insn();
    wr(`PCC_ADDR_POWER_CTRL, 8'h40);
    settle(3);
    check("pd_stale", pd, 1'b0);
    wr(`PCC_ADDR_POWER_CTRL, 8'h02);
    insn();
    wr(`PCC_ADDR_POWER_CTRL, 8'h40);
    settle(1);
    check("pd_entered", pd, 1'b1);
    check("osc_stopped", osc_run, 1'b0);
    check("loop_off_pd", loop_run, 1'b0);
    rchk("pds_reads_zero", `PCC_ADDR_POWER_CTRL, 8'h00);
    @(posedge mclk) wake <= 1'b1;
    repeat (6) @(posedge mclk);
    wake <= 1'b0;
    settle(2);
    check("pd_woken", pd, 1'b0);
    give_verdict();
  end
endmodule
